/* core/dual_async_serial_port.sv */
// Two-channel asynchronous serial port with classic Wishbone registers
// Summary of operation
// - Enable bits pick stop, receive, transmit or both; disabled pins stay ports.
// - Parity field selects none, zero (no receive check), odd or even.
// - 7-bit mode sends only bits 0..6 of the written byte.
// - 7-bit mode stores received bits 0..6; buffer bit 7 reads zero.
// - Stop-length bit chooses one or two transmitted stop bits.
// - Error-mask bit set suppresses the receive-done event for bad frames.
// - Writing the transmit byte starts a frame.
// - Transmit byte is byte-write only, unreadable, resets to all ones.
// - Receive shifter is hidden and hands each byte to the buffer.
// - Receive buffer is readable, ignores writes, resets to all ones.
// - Transmitter adds start, optional parity and stop bits per mode.
// - Receiver checks each frame and sets the matching error flag.
// - Inversion bit inverts the transmit pin level.
// - Parity error flag, status bit 2, on parity mismatch.
// - Framing error flag, status bit 1, when stop bit is low.
// - Reset clears mode, inversion and status to zero.
// - Full duplex, internal or external bit clock, reaches 1.25 Mbps at 20 MHz.
// - Overrun set when a frame completes before the buffer was read.
// - Receiver checks only the first stop bit.
// - Bit rate is clock over two to m plus one times divisor.
`timescale 1ns/1ns
module dual_async_serial_port (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [1:0]  serial_in_pin_i,
   input  wire logic [1:0]  external_baud_clock_pin_i,
   output logic      [1:0]  serial_out_pin_o,
   output logic      [1:0]  serial_out_pin_oe_o,
   output logic      [1:0]  rx_done_o,
   output logic      [1:0]  tx_done_o
);

   // ==========================================================
   // State
   uart_pkg::state_t s_q;
   uart_pkg::state_t s_d;

   logic       req;
   logic       wr;
   logic       rd;
   logic [1:0] hit_mode;
   logic [1:0] hit_err;
   logic [1:0] hit_inv;
   logic [1:0] hit_div;
   logic [1:0] hit_plo;
   logic [1:0] hit_phi;
   logic [1:0] hit_txb;
   logic [1:0] hit_rxb;
   logic [1:0] src_tick;
   logic [1:0] half_tick;
   logic [1:0] rx_tick;
   logic [1:0] clen8;
   logic [1:0][10:0] tx_frame;
   logic [1:0][3:0]  tx_len;
   logic [1:0][3:0]  rx_bits;

   // Writes and read side effects land on the edge that sees ack high
   assign req = wb_cyc_i & wb_stb_i;
   assign wr  = req & wb_we_i & s_q.ack & wb_sel_i[0];
   assign rd  = req & ~wb_we_i & s_q.ack;

   // ==========================================================
   // Per-channel decode, baud ticks and frame assembly
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [4:0]             m;
      logic [uart_pkg::PRE_W-1:0] mask;
      logic [7:0]             d;
      logic                   par_bit;
      uart_pkg::par_t         par;

      assign hit_mode[c] = wb_adr_i[9:2] == uart_pkg::IDX_MODE[c];
      assign hit_err[c]  = wb_adr_i[9:2] == uart_pkg::IDX_ERR[c];
      assign hit_inv[c]  = wb_adr_i[9:2] == uart_pkg::IDX_INV[c];
      assign hit_div[c]  = wb_adr_i[9:2] == uart_pkg::IDX_DIV[c];
      assign hit_plo[c]  = wb_adr_i[9:2] == uart_pkg::IDX_PRE_LO[c];
      assign hit_phi[c]  = wb_adr_i[9:2] == uart_pkg::IDX_PRE_HI[c];
      assign hit_txb[c]  = wb_adr_i[9:2] == uart_pkg::IDX_TXB[c];
      assign hit_rxb[c]  = wb_adr_i[9:2] == uart_pkg::IDX_RXB[c];

      // Source clock is clk/2^m or the external pin's rising edge
      assign m    = uart_pkg::tps_to_m(s_q.ch[c].tps);
      assign mask = (uart_pkg::PRE_W'(1) << m[3:0]) - uart_pkg::PRE_W'(1);
      assign src_tick[c] = (s_q.ch[c].tps == uart_pkg::TPS_EXT) ?
         (external_baud_clock_pin_i[c] & ~s_q.ch[c].ext) :
         (m[4] & ((s_q.ch[c].pre & mask) == mask));
      // A half-bit tick every k source clocks gives clk/(2^(m+1)*k)
      assign half_tick[c] = src_tick[c] & (s_q.ch[c].div >= uart_pkg::DIV_MIN)
         & (s_q.ch[c].cnt == s_q.ch[c].div - 8'h01);
      assign rx_tick[c] = src_tick[c]
         & (s_q.ch[c].div >= uart_pkg::DIV_MIN)
         & (s_q.ch[c].rx_cnt == s_q.ch[c].div - 8'h01);

      assign clen8[c] = s_q.ch[c].mode[uart_pkg::CLEN_BIT];
      assign rx_bits[c] = clen8[c] ? 4'h8 : 4'h7;
      assign par = uart_pkg::par_t'(
         s_q.ch[c].mode[uart_pkg::PAR_HI:uart_pkg::PAR_LO]);
      assign d = clen8[c] ? wb_dat_i[7:0] : {1'b0, wb_dat_i[6:0]};
      always_comb begin
         unique case (par)
            uart_pkg::PAR_ODD:  par_bit = ~^d;
            uart_pkg::PAR_EVEN: par_bit = ^d;
            default:            par_bit = 1'b0;
         endcase
      end
      // Bits after the start bit, LSB first, padded with stop level
      always_comb begin
         tx_frame[c] = 11'h7FF;
         tx_frame[c][6:0] = d[6:0];
         if (clen8[c]) begin
            tx_frame[c][7] = d[7];
         end
         if (par != uart_pkg::PAR_NONE) begin
            tx_frame[c][clen8[c] ? 8 : 7] = par_bit;
         end
         tx_len[c] = 4'h8 + {3'h0, clen8[c]}
            + {3'h0, par != uart_pkg::PAR_NONE}
            + {3'h0, s_q.ch[c].mode[uart_pkg::STOP_BIT]};
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.ack = req & ~s_q.ack;
      s_d.dat = 32'h0000_0000;
      for (int c = 0; c < 2; c++) begin
         s_d.ch[c].rx_done = 1'b0;
         s_d.ch[c].tx_done = 1'b0;
         s_d.ch[c].ext = external_baud_clock_pin_i[c];
         s_d.ch[c].pre = s_q.ch[c].pre + uart_pkg::PRE_W'(1);
         if (src_tick[c]) begin
            s_d.ch[c].cnt = half_tick[c] ? 8'h00 : s_q.ch[c].cnt + 8'h01;
            s_d.ch[c].rx_cnt = rx_tick[c] ? 8'h00 : s_q.ch[c].rx_cnt + 8'h01;
         end

         // Read data is latched with the ack; the transmit byte reads 0
         if (req & ~s_q.ack & ~wb_we_i) begin
            if (hit_mode[c]) s_d.dat[7:0] = s_q.ch[c].mode;
            if (hit_inv[c])  s_d.dat[0]   = s_q.ch[c].inv;
            if (hit_err[c])  s_d.dat[2:0] = s_q.ch[c].err;
            if (hit_div[c])  s_d.dat[7:0] = s_q.ch[c].div;
            if (hit_plo[c])  s_d.dat[2:0] = s_q.ch[c].tps[2:0];
            if (hit_phi[c])  s_d.dat[0]   = s_q.ch[c].tps[3];
            if (hit_rxb[c])  s_d.dat[7:0] = s_q.ch[c].rxb;
         end
         if (wr) begin
            if (hit_mode[c]) begin
               s_d.ch[c].mode = wb_dat_i[7:0] & uart_pkg::MODE_WMASK;
            end
            if (hit_inv[c]) s_d.ch[c].inv = wb_dat_i[0];
            if (hit_div[c]) s_d.ch[c].div = wb_dat_i[7:0];
            if (hit_plo[c]) s_d.ch[c].tps[2:0] = wb_dat_i[2:0];
            if (hit_phi[c]) s_d.ch[c].tps[3] = wb_dat_i[0];
            if (hit_txb[c]) s_d.ch[c].txs = wb_dat_i[7:0];
         end
         // Reading the buffer clears flags; a completing frame below wins
         if (rd & hit_rxb[c]) begin
            s_d.ch[c].unread = 1'b0;
            s_d.ch[c].err = 3'h0;
         end

         // Transmitter
         unique case (s_q.ch[c].tx_st)
            uart_pkg::TX_IDLE: begin
               if (wr & hit_txb[c] & s_q.ch[c].mode[uart_pkg::TXE_BIT]) begin
                  s_d.ch[c].tx_st   = uart_pkg::TX_SEND;
                  s_d.ch[c].tx_line = 1'b0;
                  s_d.ch[c].tx_sh   = tx_frame[c];
                  // Count every bit after the start, stop bits included
                  s_d.ch[c].tx_left = tx_len[c];
                  s_d.ch[c].tx_half = 1'b0;
                  // Restart the divider so the start bit is a full bit
                  s_d.ch[c].cnt     = 8'h00;
               end
            end
            uart_pkg::TX_SEND: begin
               if (half_tick[c]) begin
                  s_d.ch[c].tx_half = ~s_q.ch[c].tx_half;
                  if (s_q.ch[c].tx_half) begin
                     if (s_q.ch[c].tx_left == 4'h0) begin
                        s_d.ch[c].tx_st   = uart_pkg::TX_IDLE;
                        s_d.ch[c].tx_line = 1'b1;
                        s_d.ch[c].tx_done = 1'b1;
                     end else begin
                        s_d.ch[c].tx_line = s_q.ch[c].tx_sh[0];
                        s_d.ch[c].tx_sh = {1'b1, s_q.ch[c].tx_sh[10:1]};
                        s_d.ch[c].tx_left = s_q.ch[c].tx_left - 4'h1;
                     end
                  end
               end
            end
         endcase
         if (!s_q.ch[c].mode[uart_pkg::TXE_BIT]) begin
            s_d.ch[c].tx_st   = uart_pkg::TX_IDLE;
            s_d.ch[c].tx_line = 1'b1;
         end

         // Receiver: own divider phase so samples fall mid-bit
         unique case (s_q.ch[c].rx_st)
            uart_pkg::RX_IDLE: begin
               if (!serial_in_pin_i[c]) begin
                  s_d.ch[c].rx_st  = uart_pkg::RX_START;
                  s_d.ch[c].rx_cnt = 8'h00;
               end
            end
            uart_pkg::RX_START: begin
               if (rx_tick[c]) begin
                  // A start bit gone high at mid-bit was noise
                  s_d.ch[c].rx_st = serial_in_pin_i[c] ?
                     uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                  s_d.ch[c].rx_half = 1'b0;
                  s_d.ch[c].rx_idx  = 4'h0;
                  s_d.ch[c].rx_sh   = 8'h00;
                  s_d.ch[c].rx_pe   = 1'b0;
               end
            end
            uart_pkg::RX_DATA: begin
               if (rx_tick[c]) begin
                  s_d.ch[c].rx_half = ~s_q.ch[c].rx_half;
                  if (s_q.ch[c].rx_half) begin
                     s_d.ch[c].rx_idx = s_q.ch[c].rx_idx + 4'h1;
                     if (s_q.ch[c].rx_idx < rx_bits[c]) begin
                        s_d.ch[c].rx_sh[s_q.ch[c].rx_idx[2:0]] =
                           serial_in_pin_i[c];
                     end else if (s_q.ch[c].rx_idx == rx_bits[c] &&
                        s_q.ch[c].mode[uart_pkg::PAR_HI:uart_pkg::PAR_LO]
                        != uart_pkg::PAR_NONE) begin
                        // Zero parity has a slot but is never checked
                        if (s_q.ch[c].mode[uart_pkg::PAR_HI]) begin
                           s_d.ch[c].rx_pe = serial_in_pin_i[c] !=
                              (^s_q.ch[c].rx_sh ^
                              ~s_q.ch[c].mode[uart_pkg::PAR_LO]);
                        end
                     end else begin
                        // Only the first stop bit is looked at
                        s_d.ch[c].rx_st = uart_pkg::RX_IDLE;
                        s_d.ch[c].rxb   = s_q.ch[c].rx_sh;
                        s_d.ch[c].unread = 1'b1;
                        s_d.ch[c].err[uart_pkg::PE_BIT] =
                           s_d.ch[c].err[uart_pkg::PE_BIT] | s_q.ch[c].rx_pe;
                        s_d.ch[c].err[uart_pkg::FE_BIT] =
                           s_d.ch[c].err[uart_pkg::FE_BIT] | ~serial_in_pin_i[c];
                        s_d.ch[c].err[uart_pkg::OV_BIT] =
                           s_d.ch[c].err[uart_pkg::OV_BIT] | s_q.ch[c].unread;
                        s_d.ch[c].rx_done =
                           ~(s_q.ch[c].mode[uart_pkg::ISRM_BIT] &
                           (s_q.ch[c].rx_pe | ~serial_in_pin_i[c] |
                           s_q.ch[c].unread));
                     end
                  end
               end
            end
            default: s_d.ch[c].rx_st = uart_pkg::RX_IDLE;
         endcase
         if (!s_q.ch[c].mode[uart_pkg::RXE_BIT]) begin
            s_d.ch[c].rx_st = uart_pkg::RX_IDLE;
         end
         s_d.ch[c].pin = s_d.ch[c].tx_line ^ s_d.ch[c].inv;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
         for (int c = 0; c < 2; c++) begin
            s_q.ch[c].mode    <= uart_pkg::RST_CTRL;
            s_q.ch[c].txs     <= uart_pkg::RST_BUF;
            s_q.ch[c].rxb     <= uart_pkg::RST_BUF;
            s_q.ch[c].tx_line <= 1'b1;
            s_q.ch[c].pin     <= 1'b1;
            s_q.ch[c].tx_st   <= uart_pkg::TX_IDLE;
            s_q.ch[c].rx_st   <= uart_pkg::RX_IDLE;
         end
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.dat;
   for (genvar c = 0; c < 2; c++) begin : g_out
      assign serial_out_pin_o[c]    = s_q.ch[c].pin;
      assign serial_out_pin_oe_o[c] = s_q.ch[c].mode[uart_pkg::TXE_BIT];
      assign rx_done_o[c] = s_q.ch[c].rx_done;
      assign tx_done_o[c] = s_q.ch[c].tx_done;
   end

   // ==========================================================
   // Checks on channel 0
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_tx_write;
      wr && hit_txb[0] && s_q.ch[0].tx_st == uart_pkg::TX_IDLE
         && s_q.ch[0].mode[uart_pkg::TXE_BIT];
   endsequence
   sequence s_start_out;
      s_q.ch[0].tx_st == uart_pkg::TX_SEND && !s_q.ch[0].tx_line;
   endsequence

   a_tx_write_starts: assert property (s_tx_write |=> s_start_out)
      else $error("transmit write did not start a frame");
   a_pin_port_off: assert property
      (!s_q.ch[0].mode[uart_pkg::TXE_BIT] |-> !serial_out_pin_oe_o[0])
      else $error("transmit pin driven while disabled");
   a_txb_unreadable: assert property
      (rd && hit_txb[0] |-> wb_dat_o == 32'h0000_0000)
      else $error("transmit byte readable");
   a_rxb_ignores_wr: assert property
      (wr && hit_rxb[0] && s_q.ch[0].rx_st != uart_pkg::RX_DATA
         |=> $stable(s_q.ch[0].rxb))
      else $error("receive buffer changed by write");
   a_rxb_msb_zero: assert property
      (rx_done_o[0] && !clen8[0] |-> !s_q.ch[0].rxb[7])
      else $error("7-bit byte has bit 7 set");
   a_overrun_set: assert property
      (s_d.ch[0].rx_done && s_q.ch[0].unread
         |=> s_q.ch[0].err[uart_pkg::OV_BIT])
      else $error("overrun not flagged");
   a_err_irq_mask: assert property
      (rx_done_o[0] && s_q.ch[0].mode[uart_pkg::ISRM_BIT]
         |-> !$past(s_q.ch[0].rx_pe) && !$past(s_q.ch[0].unread))
      else $error("receive event raised for bad frame");
   a_tx_done_idle: assert property
      (tx_done_o[0] |-> s_q.ch[0].tx_st == uart_pkg::TX_IDLE
         && $past(s_q.ch[0].tx_st) == uart_pkg::TX_SEND)
      else $error("transmit done without end of frame");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule : dual_async_serial_port

/* common/uart_pkg.sv */
// Constants, register map and state types of the dual serial port
package uart_pkg;

   // ==========================================================
   // Register map: printed offsets, index = low byte, addr = 4*index
   localparam logic [31:0] OFS_MODE0    = 32'h0FFFF300;
   localparam logic [31:0] OFS_MODE1    = 32'h0FFFF310;
   localparam logic [31:0] OFS_ERR0     = 32'hFFFFF302;
   localparam logic [31:0] OFS_ERR1     = 32'hFFFFF312;
   localparam logic [31:0] OFS_INV0     = 32'hFFFFF324;
   localparam logic [31:0] OFS_INV1     = 32'hFFFFF326;
   localparam logic [31:0] OFS_DIV0     = 32'hFFFFF304;
   localparam logic [31:0] OFS_DIV1     = 32'hFFFFF314;
   localparam logic [31:0] OFS_PRE_LO0  = 32'hFFFFF30E;
   localparam logic [31:0] OFS_PRE_LO1  = 32'hFFFFF31E;
   localparam logic [31:0] OFS_PRE_HI0  = 32'hFFFFF320;
   localparam logic [31:0] OFS_PRE_HI1  = 32'hFFFFF322;
   localparam logic [31:0] OFS_TXB0     = 32'hFFFFF306;
   localparam logic [31:0] OFS_TXB1     = 32'hFFFFF316;
   localparam logic [31:0] OFS_CH0_RECEIVED_BYTE     = 32'hFFFFF308;
   localparam logic [31:0] OFS_CH1_RECEIVED_BYTE     = 32'hFFFFF318;

   localparam logic [1:0][7:0] IDX_MODE   = {OFS_MODE1[7:0], OFS_MODE0[7:0]};
   localparam logic [1:0][7:0] IDX_ERR    = {OFS_ERR1[7:0], OFS_ERR0[7:0]};
   localparam logic [1:0][7:0] IDX_INV    = {OFS_INV1[7:0], OFS_INV0[7:0]};
   localparam logic [1:0][7:0] IDX_DIV    = {OFS_DIV1[7:0], OFS_DIV0[7:0]};
   localparam logic [1:0][7:0] IDX_PRE_LO =
      {OFS_PRE_LO1[7:0], OFS_PRE_LO0[7:0]};
   localparam logic [1:0][7:0] IDX_PRE_HI =
      {OFS_PRE_HI1[7:0], OFS_PRE_HI0[7:0]};
   localparam logic [1:0][7:0] IDX_TXB    = {OFS_TXB1[7:0], OFS_TXB0[7:0]};
   localparam logic [1:0][7:0] IDX_RXB    = {OFS_CH1_RECEIVED_BYTE[7:0], OFS_CH0_RECEIVED_BYTE[7:0]};

   // ==========================================================
   // Field positions and reset values
   localparam int TXE_BIT  = 7;
   localparam int RXE_BIT  = 6;
   localparam int PAR_HI   = 5;
   localparam int PAR_LO   = 4;
   localparam int CLEN_BIT = 3;
   localparam int STOP_BIT = 2;
   localparam int ISRM_BIT = 1;
   localparam int PE_BIT   = 2;
   localparam int FE_BIT   = 1;
   localparam int OV_BIT   = 0;
   localparam logic [7:0] MODE_WMASK = 8'hFE;
   localparam logic [7:0] RST_CTRL   = 8'h00;
   localparam logic [7:0] RST_BUF    = 8'hFF;
   localparam logic [7:0] DIV_MIN    = 8'h08;
   localparam logic [3:0] TPS_EXT    = 4'h0;
   localparam logic [3:0] TPS_TIMER  = 4'h7;
   localparam logic [3:0] TPS_LAST   = 4'hB;
   localparam int         PRE_W      = 10;
   localparam int         CLK_HZ     = 20_000_000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD  = 2'b10,
      PAR_EVEN = 2'b11
   } par_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } tx_st_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10
   } rx_st_t;

   typedef struct packed {
      logic [7:0]       mode;
      logic             inv;
      logic [2:0]       err;
      logic [7:0]       rxb;
      logic [7:0]       txs;
      logic [7:0]       div;
      logic [3:0]       tps;
      logic [PRE_W-1:0] pre;
      logic [7:0]       cnt;
      logic             ext;
      tx_st_t           tx_st;
      logic             tx_line;
      logic             pin;
      logic [10:0]      tx_sh;
      logic [3:0]       tx_left;
      logic             tx_half;
      logic             tx_done;
      rx_st_t           rx_st;
      logic [7:0]       rx_cnt;
      logic             rx_half;
      logic [3:0]       rx_idx;
      logic [7:0]       rx_sh;
      logic             rx_pe;
      logic             unread;
      logic             rx_done;
   } chan_t;

   typedef struct packed {
      chan_t [1:0] ch;
      logic        ack;
      logic [31:0] dat;
   } state_t;

   // Source clock exponent for a prescale code; valid low for others
   function automatic logic [4:0] tps_to_m(input logic [3:0] tps);
      logic [4:0] r;
      r = 5'h00;
      if (tps != TPS_EXT && tps != TPS_TIMER && tps <= TPS_LAST) begin
         r[4] = 1'b1;
         r[3:0] = (tps < TPS_TIMER) ? tps - 4'h1 : tps - 4'h2;
      end
      return r;
   endfunction : tps_to_m

endpackage : uart_pkg

/* verification/remote_node.sv */
// Remote serial node: frame sender and line monitor
`timescale 1ns/1ns
module remote_node #(parameter int BIT = 16) (
   input  wire logic        clk_i,
   input  wire logic        line_i,
   input  wire logic        mon_en_i,
   output logic             line_o,
   output logic             busy_o,
   output logic             fv_o,
   output logic [11:0]      fr_o
);
   initial begin
      line_o = 1'b1;
      busy_o = 1'b0;
      fv_o = 1'b0;
      fr_o = 12'h000;
   end
   // ====
   // Sends twelve bits LSB first, then idles at mark level
   task automatic send(input logic [11:0] f);
      for (int i = 0; i < 12; i++) begin
         line_o <= f[i];
         repeat (BIT) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask : send
   // ====
   // Mid-bit sampling; idle ones after the last stop pad the capture
   always begin
      @(negedge line_i iff mon_en_i);
      busy_o <= 1'b1;
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 12; i++) begin
         fr_o[i] <= line_i;
         if (i < 11) repeat (BIT) @(posedge clk_i);
      end
      fv_o <= 1'b1;
      @(posedge clk_i);
      fv_o <= 1'b0;
      busy_o <= 1'b0;
   end
endmodule : remote_node

/* verification/dual_async_serial_port_tb_top.sv */
// Self-checking bench for the dual serial port
`timescale 1ns/1ns
module dual_async_serial_port_tb_top;
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic        ack, nl, busy, fv;
   logic        mon_en = 1'b1;
   logic [1:0]  so, oe, rxd, txd;
   logic [11:0] fr;
   logic [31:0] seed = 32'h30FA;
   logic [31:0] rd_q[$];
   logic [11:0] fr_q[$];
   logic [7:0]  d, m;
   int          n_fail = 0;
   int          n_compared = 0;
   int          n_rxd = 0;
   always #25 clk_i = ~clk_i;
   dual_async_serial_port dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .serial_in_pin_i({so[1], nl}), .external_baud_clock_pin_i(2'b00),
      .serial_out_pin_o(so), .serial_out_pin_oe_o(oe),
      .rx_done_o(rxd), .tx_done_o(txd));
   remote_node u_node (.clk_i(clk_i), .line_i(so[0]), .mon_en_i(mon_en),
      .line_o(nl), .busy_o(busy), .fv_o(fv), .fr_o(fr));
   // ====
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // Expected line bits: start, data, parity, stops as idle ones
   function automatic logic [11:0] frm(input logic [7:0] v, md);
      logic [11:0] f;
      int i;
      f = 12'hFFE;
      if (!md[3]) v[7] = 1'b0;
      i = md[3] ? 9 : 8;
      for (int j = 0; j < 8; j++) if (j < i - 1) f[j + 1] = v[j];
      case (md[5:4])
         2'b01: f[i] = 1'b0;
         2'b10: f[i] = ~^v;
         2'b11: f[i] = ^v;
         default: ;
      endcase
      return f;
   endfunction : frm
   task automatic wb(input logic w, input logic [7:0] ix, v, e);
      int t;
      t = 0;
      if (!w) rd_q.push_back({24'h0, e});
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wd <= {24'h0, v};
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 50);
      cyc <= 1'b0;
      if (t >= 50) chk("bus ack", 1, 0);
   endtask : wb
   // Frame boundary: wait for the done pulse and the monitor to finish
   task automatic settle(input int c);
      int t;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (txd[c] !== 1'b1 && t < 2000);
      // For frames under twelve bits the monitor still samples idle bits after the done pulse
      while (busy === 1'b1 && t < 2000) begin
         @(posedge clk_i);
         t++;
      end
      if (t >= 2000) chk("tx done", 1, 0);
   endtask : settle
   // ====
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
         chk("read data", rd_q.pop_front(), rdat);
      if (fv === 1'b1)
         chk("tx frame", fr_q.size() ? fr_q.pop_front() : 12'h0, fr);
      if (rxd[0] === 1'b1) n_rxd++;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         wb(0, uart_pkg::IDX_MODE[c], 0, 8'h00);
         wb(0, uart_pkg::IDX_ERR[c], 0, 8'h00);
         wb(0, uart_pkg::IDX_INV[c], 0, 8'h00);
         wb(0, uart_pkg::IDX_RXB[c], 0, 8'hFF);
         wb(0, uart_pkg::IDX_TXB[c], 0, 8'h00);
         wb(1, uart_pkg::IDX_DIV[c], 8'h08, 0);
         wb(1, uart_pkg::IDX_PRE_LO[c], 8'h01, 0);
      end
      wb(0, 8'hFF, 0, 8'h00);
      for (int p = 0; p < 9; p++) begin
         m = (p == 8) ? 8'hFC : {2'b11, p[1:0], p[2], 3'b000};
         d = rnd();
         wb(1, uart_pkg::IDX_MODE[0], m, 0);
         fr_q.push_back(frm(d, m));
         wb(1, uart_pkg::IDX_TXB[0], d, 0);
         settle(0);
      end
      d = rnd();
      u_node.send(frm(d, 8'hFC));
      chk("rx done count", 1, n_rxd);
      wb(1, uart_pkg::IDX_RXB[0], 8'h00, 0);
      wb(1, uart_pkg::IDX_ERR[0], 8'h07, 0);
      wb(0, uart_pkg::IDX_ERR[0], 0, 8'h00);
      wb(0, uart_pkg::IDX_RXB[0], 0, d);
      d = rnd();
      u_node.send(frm(d, 8'hFC) ^ 12'h200);
      wb(0, uart_pkg::IDX_ERR[0], 0, 8'h04);
      wb(0, uart_pkg::IDX_RXB[0], 0, d);
      u_node.send(frm(d, 8'hFC) & 12'hBFF);
      wb(0, uart_pkg::IDX_ERR[0], 0, 8'h02);
      wb(0, uart_pkg::IDX_RXB[0], 0, d);
      u_node.send(frm(8'h11, 8'hFC));
      u_node.send(frm(8'hC5, 8'hFC));
      wb(0, uart_pkg::IDX_ERR[0], 0, 8'h01);
      wb(0, uart_pkg::IDX_RXB[0], 0, 8'hC5);
      wb(1, uart_pkg::IDX_MODE[0], 8'h76, 0);
      u_node.send(frm(8'hD3, 8'h76));
      wb(0, uart_pkg::IDX_RXB[0], 0, 8'h53);
      u_node.send(frm(8'h53, 8'h76) ^ 12'h100);
      chk("rx done count", 6, n_rxd);
      mon_en <= 1'b0;
      wb(1, uart_pkg::IDX_MODE[0], 8'h80, 0);
      wb(1, uart_pkg::IDX_INV[0], 8'h01, 0);
      repeat (3) @(posedge clk_i);
      chk("pin inverted", 2'b10, {oe[0], so[0]});
      wb(1, uart_pkg::IDX_INV[0], 8'h00, 0);
      wb(1, uart_pkg::IDX_MODE[0], 8'h40, 0);
      repeat (3) @(posedge clk_i);
      chk("pin port", 2'b01, {oe[0], so[0]});
      d = rnd();
      wb(1, uart_pkg::IDX_MODE[1], 8'hFC, 0);
      wb(1, uart_pkg::IDX_TXB[1], d, 0);
      settle(1);
      wb(0, uart_pkg::IDX_ERR[1], 0, 8'h00);
      wb(0, uart_pkg::IDX_RXB[1], 0, d);
      repeat (2) @(posedge clk_i);
      chk("pending", 0, rd_q.size() + fr_q.size());
      wrap_up();
   end
endmodule : dual_async_serial_port_tb_top
